// ### design/line_coding.sv
// Purpose: transmit scrambler, NRZI and three-level split; receive decode,
//          descrambler with lock and hold timer, symbol assembly and alignment
// Assumes: one line bit per clk cycle; pins are asynchronous to clk
// Notes: transmit code-groups are buffered; an empty buffer sends idles
`timescale 1ns/100ps
`default_nettype none
module line_coding
    import line_coding_pkg::*;
#(
    parameter int HOLD_CYCLES_P = line_coding_pkg::HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [line_coding_pkg::ADDR_W-1:0] station_address_pins,
    input wire logic [line_coding_pkg::GROUP_W-1:0] tx_group,
    input wire logic tx_group_valid,
    output logic tx_group_ready,
    output logic tx_line_pos,
    output logic tx_line_neg,
    input wire logic rx_line_pos,
    input wire logic rx_line_neg,
    input wire logic rx_energy,
    input wire logic rx_link_pulse,
    output logic signal_detect,
    output logic [line_coding_pkg::GROUP_W-1:0] rx_symbol,
    output logic rx_symbol_valid,
    output logic rx_locked,
    output logic rx_aligned
);

    // key bit from the two feedback taps
    function automatic logic key_bit(input logic [LFSR_W-1:0] s);
        key_bit = s[TAP_HI] ^ s[TAP_LO];
    endfunction : key_bit

    // seed built from the address; the fixed one keeps it non-zero
    function automatic logic [LFSR_W-1:0] seed_of(input logic [ADDR_W-1:0] a);
        seed_of = {1'b1, a, ~a};
    endfunction : seed_of

    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES_P - 1);
    localparam logic [ONES_W-1:0] LOCK_ONES_C = ONES_W'(LOCK_ONES);
    localparam logic [ONES_W-1:0] HOLD_BITS_C = ONES_W'(HOLD_BITS);
    localparam logic [2:0] LAST_BIT = 3'(GROUP_W - 1);

    // pin synchronisers
    logic [ADDR_W-1:0] addr_s1_r, addr_s2_r;
    logic pos_s1_r, pos_s2_r, neg_s1_r, neg_s2_r;
    logic energy_s1_r, energy_s2_r, pulse_s1_r, pulse_s2_r;

    // two flops per asynchronous input
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            addr_s1_r <= '0;
            addr_s2_r <= '0;
            pos_s1_r <= 1'b0;
            pos_s2_r <= 1'b0;
            neg_s1_r <= 1'b0;
            neg_s2_r <= 1'b0;
            energy_s1_r <= 1'b0;
            energy_s2_r <= 1'b0;
            pulse_s1_r <= 1'b0;
            pulse_s2_r <= 1'b0;
        end else begin
            addr_s1_r <= station_address_pins;
            addr_s2_r <= addr_s1_r;
            pos_s1_r <= rx_line_pos;
            pos_s2_r <= pos_s1_r;
            neg_s1_r <= rx_line_neg;
            neg_s2_r <= neg_s1_r;
            energy_s1_r <= rx_energy;
            energy_s2_r <= energy_s1_r;
            pulse_s1_r <= rx_link_pulse;
            pulse_s2_r <= pulse_s1_r;
        end
    end

    // transmit buffer
    group_stream_if #(.WIDTH(GROUP_W)) tx_in ();
    group_stream_if #(.WIDTH(GROUP_W)) tx_out ();

    assign tx_in.data = tx_group;
    assign tx_in.valid = tx_group_valid;
    assign tx_group_ready = tx_in.ready;

    group_fifo #(
        .WIDTH(GROUP_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .reset(reset),
        .fill(tx_in),
        .drain(tx_out)
    );

    // transmit path
    tx_state_t tx_state_r, tx_state_nxt;
    logic [1:0] seed_cnt_r, seed_cnt_nxt;
    logic [LFSR_W-1:0] tx_lfsr_r, tx_lfsr_nxt;
    logic [2:0] tx_cnt_r, tx_cnt_nxt;
    logic [GROUP_W-1:0] tx_shift_r, tx_shift_nxt;
    logic tx_nrzi_r, tx_nrzi_nxt;
    logic tx_phase_r, tx_phase_nxt;
    logic tx_pos_r, tx_pos_nxt, tx_neg_r, tx_neg_nxt;

    // a group is taken only at a group boundary, so the buffer really fills
    assign tx_out.ready = (tx_state_r == TX_RUNNING) && (tx_cnt_r == 3'h0);

    // next transmit state: serialise, scramble, NRZI, split
    always_comb begin
        logic [GROUP_W-1:0] group;
        logic plain_bit;
        logic scr_bit;
        group = IDLE_GROUP;
        plain_bit = 1'b0;
        scr_bit = 1'b0;
        tx_state_nxt = tx_state_r;
        seed_cnt_nxt = seed_cnt_r;
        tx_lfsr_nxt = tx_lfsr_r;
        tx_cnt_nxt = tx_cnt_r;
        tx_shift_nxt = tx_shift_r;
        tx_nrzi_nxt = tx_nrzi_r;
        tx_phase_nxt = tx_phase_r;
        tx_pos_nxt = 1'b0;
        tx_neg_nxt = 1'b0;
        case (tx_state_r)
            TX_SEEDING: begin
                // wait for the synchronised address, then load the seed
                if (seed_cnt_r == SEED_WAIT) begin
                    tx_lfsr_nxt = seed_of(addr_s2_r);
                    tx_state_nxt = TX_RUNNING;
                end else begin
                    seed_cnt_nxt = seed_cnt_r + 2'h1;
                end
            end
            TX_RUNNING: begin
                if (tx_cnt_r == 3'h0) begin
                    group = tx_out.valid ? tx_out.data : IDLE_GROUP; // idle fill when empty
                    plain_bit = group[GROUP_W-1];
                    tx_shift_nxt = {group[GROUP_W-2:0], 1'b0};
                end else begin
                    plain_bit = tx_shift_r[GROUP_W-1];
                    tx_shift_nxt = {tx_shift_r[GROUP_W-2:0], 1'b0};
                end
                tx_cnt_nxt = (tx_cnt_r == LAST_BIT) ? 3'h0 : tx_cnt_r + 3'h1;
                scr_bit = plain_bit ^ key_bit(tx_lfsr_r);
                tx_lfsr_nxt = {tx_lfsr_r[LFSR_W-2:0], key_bit(tx_lfsr_r)};
                tx_nrzi_nxt = tx_nrzi_r ^ scr_bit;
                // every rise of the NRZI level goes to the other stream
                tx_phase_nxt = tx_phase_r ^ (scr_bit & ~tx_nrzi_r);
                tx_pos_nxt = tx_nrzi_nxt & ~tx_phase_nxt;
                tx_neg_nxt = tx_nrzi_nxt & tx_phase_nxt;
            end
            default: begin
                tx_state_nxt = TX_SEEDING;
            end
        endcase
    end

    // transmit registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_state_r <= TX_SEEDING;
            seed_cnt_r <= 2'h0;
            tx_lfsr_r <= '1;
            tx_cnt_r <= 3'h0;
            tx_shift_r <= '0;
            tx_nrzi_r <= 1'b0;
            tx_phase_r <= 1'b0;
            tx_pos_r <= 1'b0;
            tx_neg_r <= 1'b0;
        end else begin
            tx_state_r <= tx_state_nxt;
            seed_cnt_r <= seed_cnt_nxt;
            tx_lfsr_r <= tx_lfsr_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_shift_r <= tx_shift_nxt;
            tx_nrzi_r <= tx_nrzi_nxt;
            tx_phase_r <= tx_phase_nxt;
            tx_pos_r <= tx_pos_nxt;
            tx_neg_r <= tx_neg_nxt;
        end
    end

    assign tx_line_pos = tx_pos_r;
    assign tx_line_neg = tx_neg_r;

    // receive path
    ds_state_t ds_state_r, ds_state_nxt;
    logic rx_nrzi_prev_r, rx_nrzi_prev_nxt;
    logic [LFSR_W-1:0] rx_lfsr_r, rx_lfsr_nxt;
    logic [ONES_W-1:0] ones_r, ones_nxt;
    logic [HOLD_W-1:0] hold_r, hold_nxt;
    logic [9:0] hist_r, hist_nxt;
    logic [2:0] rx_cnt_r, rx_cnt_nxt;
    logic [GROUP_W-1:0] sym_r, sym_nxt;
    logic sym_valid_r, sym_valid_nxt;
    logic aligned_r, aligned_nxt;
    logic sd_r, sd_nxt;

    // next receive state: decode, descramble, lock, hold, assemble
    always_comb begin
        logic nrzi;
        logic scrambled_stream;
        logic key;
        logic plain_stream;
        nrzi = pos_s2_r | neg_s2_r;
        scrambled_stream = nrzi ^ rx_nrzi_prev_r;
        key = key_bit(rx_lfsr_r);
        plain_stream = scrambled_stream ^ key;
        rx_nrzi_prev_nxt = nrzi;
        ds_state_nxt = ds_state_r;
        rx_lfsr_nxt = {rx_lfsr_r[LFSR_W-2:0], key};
        hold_nxt = hold_r;
        hist_nxt = {hist_r[8:0], plain_stream};
        rx_cnt_nxt = rx_cnt_r;
        sym_nxt = sym_r;
        sym_valid_nxt = 1'b0;
        aligned_nxt = aligned_r;
        // run of consecutive unscrambled ones, saturating
        if (!plain_stream) begin
            ones_nxt = '0;
        end else if (ones_r == ONES_MAX) begin
            ones_nxt = ones_r;
        end else begin
            ones_nxt = ones_r + 1'b1;
        end
        // line carries energy but not just link pulses
        sd_nxt = energy_s2_r & ~pulse_s2_r;
        case (ds_state_r)
            DS_HUNT: begin
                // assume idle ones: the scrambled bit inverted is the key
                rx_lfsr_nxt = {rx_lfsr_r[LFSR_W-2:0], ~scrambled_stream};
                aligned_nxt = 1'b0;
                rx_cnt_nxt = 3'h0;
                if (ones_nxt >= LOCK_ONES_C) begin
                    ds_state_nxt = DS_LOCKED;
                    hold_nxt = HOLD_LOAD;
                    ones_nxt = '0;
                end
            end
            DS_LOCKED: begin
                if (ones_nxt == HOLD_BITS_C) begin
                    // idle run inside this interval; the count restarts so idles keep reloading
                    hold_nxt = HOLD_LOAD;
                    ones_nxt = '0;
                end else if (hold_r == '0) begin
                    // expiry throws away lock, alignment, the ones run and the bit count
                    ds_state_nxt = DS_HUNT;
                    ones_nxt = '0;
                    aligned_nxt = 1'b0;
                    rx_cnt_nxt = 3'h0;
                end else begin
                    hold_nxt = hold_r - 1'b1;
                end
                if (ds_state_nxt == DS_LOCKED) begin
                    if (hist_nxt == JK_PAIR) begin
                        // boundary fixed at the end of the J/K pair
                        aligned_nxt = 1'b1;
                        sym_nxt = hist_nxt[GROUP_W-1:0];
                        sym_valid_nxt = 1'b1;
                        rx_cnt_nxt = 3'h0;
                    end else if (rx_cnt_r == LAST_BIT) begin
                        sym_nxt = hist_nxt[GROUP_W-1:0];
                        sym_valid_nxt = 1'b1;
                        rx_cnt_nxt = 3'h0;
                    end else begin
                        rx_cnt_nxt = rx_cnt_r + 3'h1;
                    end
                end
            end
            default: begin
                ds_state_nxt = DS_HUNT;
            end
        endcase
    end

    // receive registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ds_state_r <= DS_HUNT;
            rx_nrzi_prev_r <= 1'b0;
            rx_lfsr_r <= '0;
            ones_r <= '0;
            hold_r <= '0;
            hist_r <= '0;
            rx_cnt_r <= 3'h0;
            sym_r <= '0;
            sym_valid_r <= 1'b0;
            aligned_r <= 1'b0;
            sd_r <= 1'b0;
        end else begin
            ds_state_r <= ds_state_nxt;
            rx_nrzi_prev_r <= rx_nrzi_prev_nxt;
            rx_lfsr_r <= rx_lfsr_nxt;
            ones_r <= ones_nxt;
            hold_r <= hold_nxt;
            hist_r <= hist_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            sym_r <= sym_nxt;
            sym_valid_r <= sym_valid_nxt;
            aligned_r <= aligned_nxt;
            sd_r <= sd_nxt;
        end
    end

    assign rx_symbol = sym_r;
    assign rx_symbol_valid = sym_valid_r;
    assign rx_locked = (ds_state_r == DS_LOCKED);
    assign rx_aligned = aligned_r;
    assign signal_detect = sd_r;

endmodule : line_coding
`default_nettype wire

// ### design/line_coding_pkg.sv
// Purpose: shared constants for the 100 Mb/s scramble and line-coding path
// Assumes: one bit per clock at the 25 MHz symbol clock
// Notes: timing counts are derived from printed times and the clock period
package line_coding_pkg;

    // code-group and address widths
    localparam int GROUP_W = 5;
    localparam int ADDR_W = 5;
    localparam int LFSR_W = 11;

    // lfsr feedback taps for x^11 + x^9 + 1
    localparam int TAP_HI = 10;
    localparam int TAP_LO = 8;

    // code-group patterns
    localparam logic [4:0] IDLE_GROUP = 5'h1F;
    localparam logic [9:0] JK_PAIR = 10'h311;

    // descrambler lock: twelve idles of five ones each
    localparam int LOCK_IDLES = 12;
    localparam int LOCK_ONES = LOCK_IDLES * GROUP_W;
    localparam int HOLD_BITS = 58;
    localparam int ONES_W = 7;
    localparam logic [6:0] ONES_MAX = 7'h7F;

    // hold timer: longest time, rounded down to whole cycles
    localparam int CLK_PERIOD_NS = 40;
    localparam int HOLD_TIME_US = 722;
    localparam int HOLD_CYCLES = (HOLD_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int HOLD_W = 15;

    // cycles to wait after reset before sampling the synced address pins
    localparam logic [1:0] SEED_WAIT = 2'h3;

    // transmit buffer shape
    localparam int FIFO_DEPTH = 16;

    // state encodings
    typedef enum logic [0:0] {
        TX_SEEDING = 1'b0,
        TX_RUNNING = 1'b1
    } tx_state_t;

    typedef enum logic [0:0] {
        DS_HUNT = 1'b0,
        DS_LOCKED = 1'b1
    } ds_state_t;

endpackage : line_coding_pkg

// ### design/group_stream_if.sv
// Purpose: valid/ready carrier for code-groups between the block's modules
// Assumes: single clock domain
// Notes: data is held stable by the source while valid is high
`timescale 1ns/100ps
`default_nettype none
interface group_stream_if #(parameter int WIDTH = 5);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : group_stream_if
`default_nettype wire

// ### design/group_fifo.sv
// Purpose: parameterised first-in first-out buffer for code-groups
// Assumes: push and pop may occur in the same cycle
// Notes: ready on the filling side drops honestly when full
`timescale 1ns/100ps
`default_nettype none
module group_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset,
    group_stream_if.snk fill,
    group_stream_if.src drain
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W:0] wr_ptr_r, wr_ptr_nxt;
    logic [PTR_W:0] rd_ptr_r, rd_ptr_nxt;
    logic full, empty, push, pop;

    // occupancy flags from the wrap bit of each pointer
    assign empty = (wr_ptr_r == rd_ptr_r);
    assign full = (wr_ptr_r[PTR_W] != rd_ptr_r[PTR_W]) && (wr_ptr_r[PTR_W-1:0] == rd_ptr_r[PTR_W-1:0]);
    assign fill.ready = !full;
    assign drain.valid = !empty;
    assign drain.data = mem_r[rd_ptr_r[PTR_W-1:0]];
    assign push = fill.valid && !full;
    assign pop = drain.ready && !empty;

    // next pointer values
    always_comb begin
        wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
        rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    end

    // pointer registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
        end
    end

    // storage, written only on an accepted push
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r[PTR_W-1:0]] <= fill.data;
        end
    end
endmodule : group_fifo
`default_nettype wire

// ### tb/line_coding_asserts.sv
// Purpose: port-level checks for line_coding
// Assumes: one clk domain, reset async active high
// Notes: bound to every line_coding instance below
`timescale 1ns/100ps
`default_nettype none
module line_coding_asserts
    import line_coding_pkg::*;
#(
    parameter int HOLD_CYCLES_P = line_coding_pkg::HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [line_coding_pkg::ADDR_W-1:0] station_address_pins,
    input wire logic [line_coding_pkg::GROUP_W-1:0] tx_group,
    input wire logic tx_group_valid,
    input wire logic tx_group_ready,
    input wire logic tx_line_pos,
    input wire logic tx_line_neg,
    input wire logic rx_line_pos,
    input wire logic rx_line_neg,
    input wire logic rx_energy,
    input wire logic rx_link_pulse,
    input wire logic signal_detect,
    input wire logic [line_coding_pkg::GROUP_W-1:0] rx_symbol,
    input wire logic rx_symbol_valid,
    input wire logic rx_locked,
    input wire logic rx_aligned
);
    logic last_neg_r;
    logic rose_yet_r;
    int since_rst_r;
    int lock_len_r;

    // last line half to rise, time since reset, length of current lock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            last_neg_r <= 1'b0;
            rose_yet_r <= 1'b0;
            since_rst_r <= 0;
            lock_len_r <= 0;
        end else begin
            if ($rose(tx_line_pos) || $rose(tx_line_neg)) rose_yet_r <= 1'b1;
            if ($rose(tx_line_pos)) last_neg_r <= 1'b0;
            else if ($rose(tx_line_neg)) last_neg_r <= 1'b1;
            if (since_rst_r < 1000) since_rst_r <= since_rst_r + 1;
            lock_len_r <= rx_locked ? lock_len_r + 1 : 0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_lines_exclusive: assert property (!(tx_line_pos && tx_line_neg))
        else $error("both line halves high");
    a_pos_alternates: assert property ($rose(tx_line_pos) |-> !rose_yet_r || last_neg_r)
        else $error("positive half rose twice in a row");
    a_neg_alternates: assert property ($rose(tx_line_neg) |-> !rose_yet_r || !last_neg_r)
        else $error("negative half rose twice in a row");
    a_detect_pulses: assert property (rx_link_pulse [*4] |-> !signal_detect)
        else $error("signal detect high on link pulses");
    a_detect_energy: assert property ((rx_energy && !rx_link_pulse) [*5] |-> signal_detect)
        else $error("signal detect low with line energy");
    a_hunt_silent: assert property (rx_symbol_valid |-> rx_locked || $past(rx_locked))
        else $error("symbol while hunting");
    a_symbol_spacing: assert property ((rx_symbol_valid && rx_aligned) |=>
        !rx_symbol_valid [*4] ##1 (rx_symbol_valid || !rx_locked))
        else $error("aligned symbols not five bits apart");
    a_align_locked: assert property (rx_aligned |-> rx_locked)
        else $error("aligned without lock");
    a_lock_earliest: assert property ($rose(rx_locked) |-> since_rst_r >= LOCK_ONES)
        else $error("lock before twelve idles");
    a_hold_length: assert property ($fell(rx_locked) |-> lock_len_r >= HOLD_CYCLES_P - 1)
        else $error("lock lost before hold time");
    a_loss_clears: assert property ($fell(rx_locked) |-> !rx_aligned && !rx_symbol_valid)
        else $error("loss of lock left alignment or symbols");
endmodule : line_coding_asserts

bind line_coding line_coding_asserts #(.HOLD_CYCLES_P(HOLD_CYCLES_P)) line_coding_asserts_inst (
    .clk(clk), .reset(reset), .station_address_pins(station_address_pins),
    .tx_group(tx_group), .tx_group_valid(tx_group_valid), .tx_group_ready(tx_group_ready),
    .tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg), .rx_line_pos(rx_line_pos),
    .rx_line_neg(rx_line_neg), .rx_energy(rx_energy), .rx_link_pulse(rx_link_pulse),
    .signal_detect(signal_detect), .rx_symbol(rx_symbol), .rx_symbol_valid(rx_symbol_valid),
    .rx_locked(rx_locked), .rx_aligned(rx_aligned)
);
`default_nettype wire

// ### tb/link_partner_model.sv
// Purpose: far end of the twisted pair for the line coding bench
// Assumes: mode 0 silent, 1 echoes our line back, 2 link pulses only
// Notes: one cycle of cable delay; a silent pair sits at the zero level
`timescale 1ns/100ps
`default_nettype none
module link_partner_model (
    input wire logic clk,
    input wire logic [1:0] mode,
    input wire logic tx_pos,
    input wire logic tx_neg,
    output logic rx_pos,
    output logic rx_neg,
    output logic energy,
    output logic link_pulse
);
    logic pos_d = 1'b0;
    logic neg_d = 1'b0;

    // cable delay on the echoed pair
    always @(posedge clk) begin
        pos_d <= tx_pos;
        neg_d <= tx_neg;
    end

    // only echo mode puts symbols on the pair
    assign rx_pos = (mode == 2'h1) & pos_d;
    assign rx_neg = (mode == 2'h1) & neg_d;
    assign energy = (mode != 2'h0);
    assign link_pulse = (mode == 2'h2);
endmodule : link_partner_model
`default_nettype wire

// ### tb/tb_line_coding.sv
// Purpose: self-checking bench for line_coding
// Assumes: partner echoes our own line back as the far end for the fifo, align and hold tests
// Notes: hold timer shortened to keep the run brief
`timescale 1ns/100ps
`default_nettype none
module tb_line_coding;
    import line_coding_pkg::*;
    localparam int HOLD = 400;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] station_address_pins = 5'h00;
    logic [GROUP_W-1:0] tx_group = 5'h1F;
    logic tx_group_valid = 1'b0;
    logic [1:0] mode = 2'h0;
    logic tx_group_ready, tx_line_pos, tx_line_neg, rx_line_pos, rx_line_neg;
    logic rx_energy, rx_link_pulse, signal_detect, rx_symbol_valid, rx_locked, rx_aligned;
    logic [GROUP_W-1:0] rx_symbol;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;

    // clock and free cycle count
    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    line_coding #(.HOLD_CYCLES_P(HOLD)) line_coding_inst (
        .clk(clk), .reset(reset), .station_address_pins(station_address_pins),
        .tx_group(tx_group), .tx_group_valid(tx_group_valid), .tx_group_ready(tx_group_ready),
        .tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg), .rx_line_pos(rx_line_pos),
        .rx_line_neg(rx_line_neg), .rx_energy(rx_energy), .rx_link_pulse(rx_link_pulse),
        .signal_detect(signal_detect), .rx_symbol(rx_symbol), .rx_symbol_valid(rx_symbol_valid),
        .rx_locked(rx_locked), .rx_aligned(rx_aligned)
    );

    link_partner_model link_partner_model_inst (
        .clk(clk), .mode(mode), .tx_pos(tx_line_pos), .tx_neg(tx_line_neg), .rx_pos(rx_line_pos),
        .rx_neg(rx_line_neg), .energy(rx_energy), .link_pulse(rx_link_pulse)
    );

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_cnt(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk_cnt

    // reset with given straps and partner mode, returns on release edge
    task automatic do_reset(input logic [4:0] addr, input logic [1:0] m);
        @(posedge clk);
        reset <= 1'b1;
        station_address_pins <= addr;
        mode <= m;
        tx_group_valid <= 1'b0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
    endtask : do_reset

    // bounded wait for lock, n is cycles waited
    task automatic wait_lock(output int n);
        n = 0;
        while (rx_locked !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 300) begin
                chk_val(16'h0000, 16'h0001);
                give_verdict();
            end
        end
    endtask : wait_lock

    // offer one group, held until ready seen at a falling edge and the next rising edge
    task automatic push(input logic [4:0] g);
        logic ok;
        tx_group <= g;
        tx_group_valid <= 1'b1;
        ok = 1'b0;
        for (int i = 0; i < 50 && ok !== 1'b1; i++) begin
            @(negedge clk);
            ok = tx_group_ready;
            @(posedge clk);
        end
        chk_val(ok, 1'b1);
    endtask : push

    // idle line level sequence must match a reference scrambler from the seed
    task automatic t_seed(input logic [4:0] addr);
        logic [LFSR_W-1:0] l;
        logic lv;
        logic [63:0] obs;
        logic [31:0] ex;
        int hit;
        do_reset(addr, 2'h0);
        for (int i = 0; i < 64; i++) begin
            @(negedge clk);
            obs[i] = tx_line_pos | tx_line_neg;
        end
        l = {1'b1, addr, ~addr};
        lv = 1'b0;
        for (int i = 0; i < 32; i++) begin
            lv = lv ^ ~(l[TAP_HI] ^ l[TAP_LO]);
            l = {l[LFSR_W-2:0], l[TAP_HI] ^ l[TAP_LO]};
            ex[i] = lv;
        end
        hit = 0;
        for (int k = 0; k < 32; k++) begin
            if (obs[k +: 32] === ex) hit = 1;
        end
        chk_val(hit, 1);
    endtask : t_seed

    // signal detect against link pulses, energy and silence
    task automatic t_detect();
        logic [1:0] m [3];
        m = '{2'h2, 2'h1, 2'h0};
        do_reset(5'h01, 2'h2);
        foreach (m[i]) begin
            @(posedge clk);
            mode <= m[i];
            repeat (6) @(negedge clk);
            chk_val(signal_detect, m[i] == 2'h1);
        end
    endtask : t_detect

    // fill the transmit buffer until it refuses, then let it drain
    task automatic t_fifo();
        int n;
        do_reset(5'h10, 2'h1);
        tx_group <= IDLE_GROUP;
        tx_group_valid <= 1'b1;
        n = 0;
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            if (tx_group_ready !== 1'b1) break;
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        tx_group_valid <= 1'b0;
        chk_cnt(n, FIFO_DEPTH, FIFO_DEPTH + 6);
        repeat (100) @(posedge clk);
        chk_val(tx_group_ready, 1'b1);
    endtask : t_fifo

    // start pair then data looped back, aligned and descrambled; idles reload hold
    task automatic t_align();
        logic [4:0] grp [5];
        logic [4:0] got [$];
        int n;
        int c0;
        grp = '{5'h18, 5'h11, 5'h0E, 5'h15, 5'h07};
        do_reset(5'h07, 2'h1);
        wait_lock(n);
        c0 = cyc;
        @(posedge clk);
        foreach (grp[i]) push(grp[i]);
        tx_group_valid <= 1'b0;
        for (int i = 0; i < 200 && got.size() < 4; i++) begin
            @(negedge clk);
            if (rx_symbol_valid === 1'b1 && (rx_aligned === 1'b1 || got.size() > 0)) got.push_back(rx_symbol);
        end
        chk_cnt(got.size(), 4, 4);
        for (int i = 0; i < got.size(); i++) chk_val(got[i], grp[i + 1]);
        while (cyc - c0 < HOLD + 40 && rx_locked === 1'b1) @(negedge clk);
        chk_val(rx_locked, 1'b1);
    endtask : t_align

    // idles keep reloading the hold; data with no idle run lets lock expire, then it is sought again
    task automatic t_hold();
        int n;
        int c0;
        do_reset(5'h0C, 2'h1);
        wait_lock(n);
        chk_cnt(n, LOCK_ONES, 300);
        n = 0;
        for (int i = 0; i < HOLD + 60; i++) begin
            @(negedge clk);
            if (rx_locked === 1'b1) n++;
        end
        chk_cnt(n, HOLD + 60, HOLD + 60);
        @(posedge clk);
        c0 = cyc;
        push(5'h18);
        push(5'h11);
        while (cyc - c0 < HOLD - 70) push(5'h15);
        @(negedge clk);
        chk_val({rx_locked, rx_aligned}, 2'h3);
        @(posedge clk);
        while (cyc - c0 < HOLD + 40) push(5'h15);
        @(negedge clk);
        chk_val(rx_locked, 1'b0);
        chk_val(rx_aligned, 1'b0);
        @(posedge clk);
        tx_group_valid <= 1'b0;
        wait_lock(n);
        chk_cnt(n, LOCK_ONES, 300);
    endtask : t_hold

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_seed(5'h00);
        t_seed(5'h1A);
        t_detect();
        t_fifo();
        t_align();
        t_hold();
        give_verdict();
    end
endmodule : tb_line_coding
`default_nettype wire
